// [hw/fsw_pkg.sv]
// shared constants for the flash status and write-enable logic
package fsw_pkg;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WSR1  = 8'h01;
  localparam logic [7:0] OP_WSR2  = 8'h31;
  localparam logic [7:0] OP_WSR3  = 8'h11;

  // ==========================================================================
  // status register layout
  localparam int unsigned SR_N     = 3;
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned WEL_BIT  = 1;
  // sr1: protect_range_bits [5:2], top_bottom_select [6]
  // sr2: status_lock [0], quad_io_enable [1], security_lock_bits [5:3], protect_complement [6]
  // sr3: power_up_address_mode [0], protect_scheme_select [2], drive_strength [6:5]
  localparam logic [7:0] WR_MASK [SR_N] = '{8'h7C, 8'h7B, 8'h65};
  localparam logic [7:0] OTP_NV  [SR_N] = '{8'h00, 8'h38, 8'h00};
  localparam logic [7:0] OTP_VOL [SR_N] = '{8'h00, 8'h39, 8'h00};
  localparam logic [7:0] NV_RST  [SR_N] = '{8'h00, 8'h00, 8'h00};

  // ==========================================================================
  // link bit counts
  localparam logic [4:0] BITS_OP  = 5'h08;
  localparam logic [4:0] BITS_ONE = 5'h10;
  localparam logic [4:0] BITS_TWO = 5'h18;
  localparam logic [4:0] BITS_MAX = 5'h1F;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_MHZ   = 200;
  localparam int unsigned TW_NS     = 1000000;
  localparam int unsigned TW_CYCLES = (TW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TW_W      = 24;
  localparam int unsigned SCK_HALF_NS  = 60;
  localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  DIV_LAST     = 4'(SCK_HALF_CYC - 1);

  // ==========================================================================
  // host register map (byte addresses) and fields
  localparam logic [3:0] REG_CMD  = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int unsigned CMD_LEN_LSB = 8;
  localparam int unsigned CMD_RD_BIT  = 10;
  localparam int unsigned STAT_RX_LSB = 8;

endpackage

// [hw/fsw_link_if.sv]
// serial link between the controller and the flash status logic
`timescale 1ns/1ps
`default_nettype none
interface fsw_link_if;
  logic sclk;
  logic cs_n;
  logic serial_in_pin;
  logic serial_out_pin;

  modport dev (input sclk, input cs_n, input serial_in_pin, output serial_out_pin);
  modport host (output sclk, output cs_n, output serial_in_pin, input serial_out_pin);
endinterface
`default_nettype wire

// [hw/fsw_sync.sv]
// two-stage synchroniser with edge pulses
`timescale 1ns/1ps
`default_nettype none
module fsw_sync #(
  parameter int unsigned     W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  // system
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // pins
  input  wire logic [W-1:0] pin_in,
  // synchronised view
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] dly_r;

  // ==========================================================================
  // per-bit stages
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        meta_r[i] <= RST_VAL[i];
        sync_r[i] <= RST_VAL[i];
        dly_r[i]  <= RST_VAL[i];
      end else begin
        meta_r[i] <= pin_in[i];
        sync_r[i] <= meta_r[i];
        dly_r[i]  <= sync_r[i];
      end
    end
    assign rise[i] = sync_r[i] & ~dly_r[i];
    assign fall[i] = ~sync_r[i] & dly_r[i];
  end
  assign lvl = sync_r;
endmodule
`default_nettype wire

// [hw/fsw_dev.sv]
// flash status register and write-enable logic, device end of the link
//
// What this block does
// - write-enable opcode sets write_latch_flag
// - host sets write_latch_flag before any nonvolatile write
// - host frames single opcodes with chip select
// - volatile enable keeps flag, arms volatile write
// - host sends volatile enable right before write
// - write-disable opcode clears write_latch_flag
// - flag auto-clears on reset and completions
// - three read opcodes select status register
// - status shifted out msb first, falling edge
// - status reads accepted even while busy
// - status byte repeats until chip select rises
// - only listed status bits are writable
// - security_lock_bits return to zero only when dev_reset reloads
// - nonvolatile write needs write_latch_flag set
// - host sends write opcode then one or two bytes
// - volatile write keeps flag, lock bits sticky
// - reset reloads nonvolatile values into volatile
// - nonvolatile write starts timed cycle on rise
// - busy during cycle, then flag cleared
// - volatile values apply at once, never busy
// - sixteen data bits write registers one and two
// - eight data bits write register one only
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module fsw_dev import fsw_pkg::*; #(
  parameter int unsigned TW_CYC = TW_CYCLES
) (
  // system
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // link
  fsw_link_if.dev                   link,
  // device side events
  input  wire logic                 dev_reset,
  input  wire logic                 ext_busy,
  input  wire logic                 ext_op_done,
  // status view
  output logic [SR_N-1:0][7:0]      status_q,
  output logic                      wel_q,
  output logic                      busy_q
);

  // ==========================================================================
  // link sampling
  logic [2:0] lvl_w;
  logic [2:0] rise_w;
  logic [2:0] fall_w;

  fsw_sync #(
    .W       (3),
    .RST_VAL (3'h2)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  ({link.sclk, link.cs_n, link.serial_in_pin}),
    .lvl     (lvl_w),
    .rise    (rise_w),
    .fall    (fall_w)
  );

  wire sck_rise = rise_w[2];
  wire sck_fall = fall_w[2];
  wire cs_rise  = rise_w[1];
  wire cs_fall  = fall_w[1];
  wire cs_low   = ~lvl_w[1];
  wire din      = lvl_w[0];

  // ==========================================================================
  // state
  logic [23:0]     sh_r;
  logic [7:0]      op_r;
  logic [4:0]      cnt_r;
  logic [2:0]      obit_r;
  logic            dout_r;
  logic            wel_r;
  logic            vwe_r;
  logic            busy_r;
  logic [TW_W-1:0] tw_r;
  logic [7:0]      vol_w [SR_N];
  logic [SR_N-1:0] hit_w;
  logic [7:0]      dat_w [SR_N];

  // ==========================================================================
  // decode
  wire op_ok    = (cnt_r >= BITS_OP);
  wire any_busy = busy_r | ext_busy;
  wire single   = cs_rise & (cnt_r == BITS_OP) & ~any_busy;
  wire do_wren  = single & (op_r == OP_WREN);
  wire do_vwren = single & (op_r == OP_VWREN);
  wire do_wrdi  = single & (op_r == OP_WRDI);
  wire is_wsr   = (op_r == OP_WSR1) | (op_r == OP_WSR2) | (op_r == OP_WSR3);
  wire dual_w   = (op_r == OP_WSR1) & (cnt_r == BITS_TWO);
  wire len_ok   = (is_wsr & (cnt_r == BITS_ONE)) | dual_w;
  wire wr_ok    = cs_rise & len_ok & ~any_busy;
  wire vol_go   = wr_ok & vwe_r;
  wire nv_go    = wr_ok & ~vwe_r & wel_r;
  // a write with neither enable falls through both strobes untouched
  wire tw_done  = busy_r & (tw_r == '0);
  wire [7:0] byte_a = dual_w ? sh_r[15:8] : sh_r[7:0];

  wire rd1 = (op_r == OP_RDSR1);
  wire rd2 = (op_r == OP_RDSR2);
  wire rd3 = (op_r == OP_RDSR3);
  wire rd_hit = op_ok & (rd1 | rd2 | rd3);
  wire [7:0] sr1_rd = vol_w[0] | (8'(any_busy) << BUSY_BIT) | (8'(wel_r) << WEL_BIT);
  wire [7:0] rd_sel = rd1 ? sr1_rd : (rd2 ? vol_w[1] : vol_w[2]);

  // ==========================================================================
  // opcode and data shifting
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sh_r  <= 24'h000000;
      op_r  <= 8'h00;
      cnt_r <= 5'h00;
    end else if (cs_fall) begin
      cnt_r <= 5'h00;
    end else if (cs_low && sck_rise) begin
      sh_r <= {sh_r[22:0], din};
      if (cnt_r == BITS_OP - 5'h01) begin
        op_r <= {sh_r[6:0], din};
      end
      if (cnt_r != BITS_MAX) begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // ==========================================================================
  // status readout: falling edge, msb first, repeats while selected
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      obit_r <= 3'h0;
      dout_r <= 1'b0;
    end else if (cs_fall || !cs_low) begin
      obit_r <= 3'h0;
      dout_r <= 1'b0;
    end else if (sck_fall && rd_hit) begin
      dout_r <= rd_sel[3'h7 - obit_r];
      obit_r <= obit_r + 3'h1;
    end
  end
  assign link.serial_out_pin = dout_r;

  // ==========================================================================
  // write-enable latches; for wel_r a set beats any clear in the same cycle, for vwe_r dev_reset beats the set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wel_r <= 1'b0;
      vwe_r <= 1'b0;
    end else begin
      if (do_wren) begin
        wel_r <= 1'b1;
      end else if (do_wrdi || tw_done || ext_op_done || dev_reset) begin
        wel_r <= 1'b0;
      end
      if (dev_reset) begin
        vwe_r <= 1'b0;
      end else if (cs_rise && cnt_r != 5'h00) begin
        vwe_r <= do_vwren;
      end
    end
  end

  // ==========================================================================
  // self-timed nonvolatile write cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_r <= 1'b0;
      tw_r   <= '0;
    end else if (dev_reset) begin
      busy_r <= 1'b0;
      tw_r   <= '0;
    end else if (nv_go) begin
      busy_r <= 1'b1;
      tw_r   <= TW_W'(TW_CYC - 1);
    end else if (tw_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      tw_r <= tw_r - 1'b1;
    end
  end

  // ==========================================================================
  // status registers: volatile copy in use, nonvolatile copy behind it
  for (genvar i = 0; i < SR_N; i++) begin : g_sr
    logic [7:0] vol_r;
    logic [7:0] nv_r;
    logic [7:0] pend_r;
    logic       pend_hit_r;

    assign hit_w[i] = (op_r == (i == 0 ? OP_WSR1 : (i == 1 ? OP_WSR2 : OP_WSR3)))
                    | (dual_w & (i == 1));
    assign dat_w[i] = (dual_w && i == 1) ? sh_r[7:0] : byte_a;

    // only writable bits move; lock bits can only be raised
    wire [7:0] vol_new = (vol_r & ~WR_MASK[i]) | (dat_w[i] & WR_MASK[i])
                       | (vol_r & OTP_VOL[i]);
    wire [7:0] nv_new  = (nv_r & ~WR_MASK[i]) | (pend_r & WR_MASK[i])
                       | (nv_r & OTP_NV[i]);

    always_ff @(posedge clk_sys) begin
      if (rst) begin
        vol_r      <= NV_RST[i];
        nv_r       <= NV_RST[i];
        pend_r     <= 8'h00;
        pend_hit_r <= 1'b0;
      end else begin
        if (nv_go) begin
          pend_r     <= dat_w[i];
          pend_hit_r <= hit_w[i];
        end
        if (dev_reset) begin
          vol_r      <= nv_r;
          pend_hit_r <= 1'b0;
        end else if (tw_done && pend_hit_r) begin
          nv_r  <= nv_new;
          // security lock bits raised in the volatile copy survive the reload
          vol_r <= nv_new | (vol_r & OTP_NV[i]);
        end else if (vol_go && hit_w[i]) begin
          vol_r <= vol_new;
        end
      end
    end
    assign vol_w[i]    = vol_r;
    assign status_q[i] = vol_r;
  end

  assign wel_q  = wel_r;
  assign busy_q = busy_r;

endmodule
`default_nettype wire

// [hw/fsw_host.sv]
// serial controller end: avalon-mm command registers driving the link
`timescale 1ns/1ps
`default_nettype none
module fsw_host import fsw_pkg::*; (
  // system
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // link
  fsw_link_if.host         link
);
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_SHIFT, H_HOLD} fsw_hst_t;

  // ==========================================================================
  // state
  fsw_hst_t    st_r;
  logic [3:0]  div_r;
  logic        sck_r;
  logic        csn_r;
  logic [23:0] tx_r;
  logic [7:0]  rx_r;
  logic [4:0]  bits_r;
  logic [4:0]  total_r;
  logic [15:0] wdat_r;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        miso_s;

  fsw_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pin_in  (link.serial_out_pin),
    .lvl     (miso_s),
    .rise    (),
    .fall    ()
  );

  // ==========================================================================
  // bus decode; a command while a frame runs stalls the bus
  wire hit_cmd  = (avs_address == REG_CMD);
  wire hit_data = (avs_address == REG_DATA);
  wire hit_stat = (avs_address == REG_STAT);
  wire busy_w   = (st_r != H_IDLE);
  wire stall    = avs_write & hit_cmd & busy_w;
  wire req      = (avs_read | avs_write) & ~ack_r & ~stall;
  wire launch   = req & avs_write & hit_cmd;
  wire div_end  = (div_r == DIV_LAST);
  wire [31:0] rd_mux = hit_data ? {16'h0000, wdat_r} :
                       hit_stat ? {16'h0000, rx_r, 7'h00, busy_w} : 32'h00000000;
  // a data count of three is reserved: the byte count wraps and the frame runs long
  wire [1:0]  units_w = avs_writedata[CMD_LEN_LSB+1:CMD_LEN_LSB] + 2'h1;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata    = rdata_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h00000000;
      wdat_r  <= 16'h0000;
    end else begin
      ack_r <= req;
      if (req && avs_read) begin
        rdata_r <= rd_mux;
      end
      if (req && avs_write && hit_data) begin
        wdat_r <= avs_writedata[15:0];
      end
    end
  end

  // ==========================================================================
  // frame sequencer: opcode then data, msb first, sampled on rising edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r    <= H_IDLE;
      div_r   <= 4'h0;
      sck_r   <= 1'b0;
      csn_r   <= 1'b1;
      tx_r    <= 24'h000000;
      rx_r    <= 8'h00;
      bits_r  <= 5'h00;
      total_r <= 5'h00;
    end else begin
      div_r <= div_end ? 4'h0 : div_r + 4'h1;
      case (st_r)
        H_IDLE: begin
          div_r <= 4'h0;
          if (launch) begin
            tx_r    <= {avs_writedata[7:0], wdat_r[7:0], wdat_r[15:8]};
            total_r <= {units_w, 3'h0};
            bits_r  <= 5'h00;
            csn_r   <= 1'b0;
            st_r    <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (div_end) begin
            st_r <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (div_end && !sck_r) begin
            sck_r  <= 1'b1;
            rx_r   <= {rx_r[6:0], miso_s};
            bits_r <= bits_r + 5'h01;
          end else if (div_end) begin
            sck_r <= 1'b0;
            tx_r  <= {tx_r[22:0], 1'b0};
            if (bits_r == total_r) begin
              st_r <= H_HOLD;
            end
          end
        end
        H_HOLD: begin
          if (div_end) begin
            csn_r <= 1'b1;
            st_r  <= H_IDLE;
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end

  assign link.sclk          = sck_r;
  assign link.cs_n          = csn_r;
  assign link.serial_in_pin = tx_r[23];

endmodule
`default_nettype wire

// [tb/fsw_sva.sv]
// assertions on the serial link and the device status outputs
`timescale 1ns/1ps
`default_nettype none
module fsw_sva import fsw_pkg::*; #(
  parameter int unsigned TW_CYC = TW_CYCLES
) (
  // system
  input wire logic                  clk_sys,
  input wire logic                  rst,
  // link
  input wire logic                  sclk,
  input wire logic                  cs_n,
  input wire logic                  serial_in_pin,
  input wire logic                  serial_out_pin,
  // device view
  input wire logic                  dev_reset,
  input wire logic [SR_N-1:0][7:0]  status_q,
  input wire logic                  wel_q,
  input wire logic                  busy_q
);
  // ==================
  // busy length counter; a repetition cannot reach the write cycle length
  logic [TW_W-1:0] busy_cnt_r;
  logic [TW_W-1:0] busy_cnt_nxt;
  assign busy_cnt_nxt = busy_q ? busy_cnt_r + 1'h1 : '0;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_cnt_r <= '0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end

  // ==================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock moves outside a frame");
  a_dout_idle: assert property (cs_n [*6] |-> !serial_out_pin)
    else $error("data out not released after chip select rose");
  a_dout_edge: assert property ((!cs_n && $changed(serial_out_pin)) |-> !sclk)
    else $error("data out changed while serial clock high");
  a_wel_set: assert property ($rose(wel_q) |-> $past(cs_n, 2) && !busy_q)
    else $error("write flag set outside a frame end or while busy");
  a_nv_armed: assert property ($rose(busy_q) |-> wel_q && $past(cs_n, 2))
    else $error("write cycle started without write flag");
  a_busy_len: assert property (($fell(busy_q) && !$past(dev_reset))
    |-> busy_cnt_r == TW_W'(TW_CYC))
    else $error("write cycle length wrong");
  a_done_clear: assert property ($fell(busy_q) |-> !wel_q)
    else $error("write flag kept after write cycle");
  a_otp_sticky: assert property (!$past(dev_reset)
    |-> (($past(status_q[1]) & ~status_q[1] & OTP_NV[1]) == 8'h00))
    else $error("lock bit returned to zero");
  a_ro_bits: assert property (((status_q[0] & ~WR_MASK[0]) | (status_q[1] & ~WR_MASK[1])
    | (status_q[2] & ~WR_MASK[2])) == 8'h00)
    else $error("read-only status bit set");

  c_wel: cover property ($rose(wel_q));
  c_cycle: cover property ($fell(busy_q));
  c_read: cover property (!cs_n && $changed(serial_out_pin));
  c_vol: cover property ($changed(status_q[2]));
endmodule
`default_nettype wire

// [tb/flash_status_write_control_test.sv]
// self-checking bench: controller and device joined over the serial link
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("unexpected %0t: %h, expected %h", $time, (a), (b)); end end
module flash_status_write_control_test import fsw_pkg::*;;
  // short cycle so reads can still poll inside it
  localparam int unsigned TW_SIM = 1000;
  logic                 clk_sys, rst, dev_reset, ext_busy, ext_op_done, wel_q, busy_q;
  logic                 avs_read, avs_write, avs_waitrequest;
  logic [3:0]           avs_address;
  logic [31:0]          avs_writedata, avs_readdata, q, seed;
  logic [SR_N-1:0][7:0] status_q, e, nv;
  logic [7:0]           r, r2;
  logic [63:0]          exp_q [$];
  logic [63:0]          ent;
  int                   errors, comparisons;

  fsw_link_if fsw_link_if_i ();
  fsw_dev #(.TW_CYC(TW_SIM)) fsw_dev_i (.clk_sys(clk_sys), .rst(rst),
    .link(fsw_link_if_i.dev), .dev_reset(dev_reset), .ext_busy(ext_busy),
    .ext_op_done(ext_op_done), .status_q(status_q), .wel_q(wel_q), .busy_q(busy_q));
  fsw_host fsw_host_i (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(fsw_link_if_i.host));
  fsw_sva #(.TW_CYC(TW_SIM)) fsw_sva_i (.clk_sys(clk_sys), .rst(rst),
    .sclk(fsw_link_if_i.sclk), .cs_n(fsw_link_if_i.cs_n),
    .serial_in_pin(fsw_link_if_i.serial_in_pin), .serial_out_pin(fsw_link_if_i.serial_out_pin),
    .dev_reset(dev_reset), .status_q(status_q), .wel_q(wel_q), .busy_q(busy_q));

  // ==================
  // helpers
  initial begin
    clk_sys = 1'h0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  function logic [7:0] sr1(input logic b, input logic w);
    return e[0] | {6'h00, w, b};
  endfunction

  // reads note mask and value; a zero mask marks a poll
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] x);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    if (!wr) exp_q.push_back({m, x});
    do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  always @(posedge clk_sys) begin
    if (avs_read && avs_waitrequest === 1'h0 && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      if (ent[63:32] != 32'h0) `CHK(avs_readdata & ent[63:32], ent[31:0])
    end
  end

  task automatic frame(input logic [7:0] op, input logic [1:0] n, input logic [15:0] d);
    bus(1'h1, REG_DATA, {16'h0000, d}, '0, '0);
    bus(1'h1, REG_CMD, {22'h0, n, op}, '0, '0);
    do bus(1'h0, REG_STAT, '0, '0, '0); while (q[0] !== 1'h0);
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] op, input logic [7:0] x, input logic [1:0] n);
    frame(op, n, 16'h0000);
    bus(1'h0, REG_STAT, '0, 32'h0000FF00, {16'h0000, x, 8'h00});
  endtask

  task automatic nvw(input logic [7:0] op, input logic [1:0] n, input logic [15:0] d);
    frame(OP_WREN, 2'h0, 16'h0000);
    frame(op, n, d);
    `CHK(busy_q, 1'h1)
    rd(OP_RDSR1, sr1(1'h1, 1'h1), 2'h1);
    for (int i = 0; i < 3000 && busy_q !== 1'h0; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    `CHK(wel_q, 1'h0)
  endtask

  task test_end(input string s);
    $display("test %s finished", s);
  endtask

  task tally_and_finish();
    $display("comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #450000;
    errors++;
    $display("unexpected %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // ==================
  // tests
  initial begin
    {rst, avs_read, avs_write, dev_reset, ext_busy, ext_op_done} = 6'h20;
    avs_address = '0;
    avs_writedata = '0;
    errors = 0;
    comparisons = 0;
    seed = 32'h2259962C;
    e = '0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'h0;
    `CHK({busy_q, wel_q, status_q}, 26'h0)
    bus(1'h0, 4'hC, '0, '1, '0);
    test_end("reset");
    frame(OP_WREN, 2'h0, 16'h0000);
    `CHK(wel_q, 1'h1)
    rd(OP_RDSR1, 8'h02, 2'h1);
    frame(OP_WRDI, 2'h0, 16'h0000);
    `CHK(wel_q, 1'h0)
    frame(OP_WSR1, 2'h1, 16'h00FF);
    `CHK({busy_q, status_q}, 25'h0)
    test_end("enable");
    r = rnd() | 8'h08;
    nvw(OP_WSR2, 2'h1, {8'h00, r});
    e[1] = r & WR_MASK[1];
    `CHK(status_q, e)
    nvw(OP_WSR2, 2'h1, 16'h0000);
    e[1] = e[1] & OTP_NV[1];
    `CHK(status_q, e)
    rd(OP_RDSR2, e[1], 2'h2);
    r = rnd();
    r2 = rnd();
    nvw(OP_WSR1, 2'h2, {r2, r});
    e[0] = r & WR_MASK[0];
    e[1] = (r2 & WR_MASK[1]) | e[1];
    `CHK(status_q, e)
    r = rnd();
    nvw(OP_WSR1, 2'h1, {8'h00, r});
    e[0] = r & WR_MASK[0];
    `CHK(status_q, e)
    r = rnd();
    nvw(OP_WSR3, 2'h1, {8'h00, r});
    e[2] = r & WR_MASK[2];
    `CHK(status_q, e)
    test_end("nonvolatile");
    nv = e;
    r = rnd();
    frame(OP_VWREN, 2'h0, 16'h0000);
    `CHK(wel_q, 1'h0)
    frame(OP_WSR3, 2'h1, {8'h00, r});
    e[2] = r & WR_MASK[2];
    `CHK({busy_q, wel_q, status_q}, {2'h0, e})
    rd(OP_RDSR3, e[2], 2'h1);
    frame(OP_VWREN, 2'h0, 16'h0000);
    frame(OP_WSR2, 2'h1, 16'h00FF);
    frame(OP_VWREN, 2'h0, 16'h0000);
    frame(OP_WSR2, 2'h1, 16'h0000);
    e[1] = OTP_VOL[1];
    `CHK({wel_q, status_q}, {1'h0, e})
    frame(OP_VWREN, 2'h0, 16'h0000);
    frame(OP_WRDI, 2'h0, 16'h0000);
    frame(OP_WSR3, 2'h1, 16'h0000);
    `CHK(status_q, e)
    @(posedge clk_sys);
    dev_reset <= 1'h1;
    @(posedge clk_sys);
    dev_reset <= 1'h0;
    @(posedge clk_sys);
    e = nv;
    `CHK(status_q, e)
    test_end("volatile");
    frame(OP_WREN, 2'h0, 16'h0000);
    @(posedge clk_sys);
    ext_op_done <= 1'h1;
    @(posedge clk_sys);
    ext_op_done <= 1'h0;
    repeat (2) @(posedge clk_sys);
    `CHK(wel_q, 1'h0)
    ext_busy <= 1'h1;
    frame(OP_WREN, 2'h0, 16'h0000);
    `CHK(wel_q, 1'h0)
    rd(OP_RDSR1, sr1(1'h1, 1'h0), 2'h1);
    ext_busy <= 1'h0;
    test_end("foreign");
    tally_and_finish();
  end
endmodule
`default_nettype wire
